/* eeprom_core.sv */
`include "eeprom_regs.svh"
`default_nettype none
module eeprom_core #(
	parameter bit LARGE = 1'b1, // 1: 256-byte variant, 0: 128-byte
	parameter int PROT_CYC = `PROT_CYCLES,
	parameter int WRITE_CYC = `WRITE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic busy
);
	eeprom_pkg::core_state_t s_r; // registered state
	eeprom_pkg::core_state_t s_nxt; // next state
	eeprom_pkg::bus_pins_t pins; // synchronised wires
	logic scl_rise; // scl edge events
	logic scl_fall;
	logic start_ev; // sda falls while scl high
	logic stop_ev; // sda rises while scl high
	logic [7:0] rx_byte; // byte completed on this rising edge
	logic [4:0] page; // page of the address counter
	logic [7:0] tx_byte; // next byte to shift out

	// both wires are pin inputs and pass two flops first
	sync2 #(
		.WIDTH(2)
	) u_sync (
		.clk(core_clk),
		.rst_n(rst_n),
		.d({scl, sda_i}),
		.q(pins)
	);

	// open drain: only ever pull low
	assign sda_o = 1'b0;
	assign sda_oe = s_r.oe;
	assign busy = (s_r.timer != 20'h00000);

	// edge and condition decode on the synchronised wires
	assign scl_rise = pins.scl & ~s_r.last.scl;
	assign scl_fall = ~pins.scl & s_r.last.scl;
	assign start_ev = pins.scl & s_r.last.scl & s_r.last.sda & ~pins.sda;
	assign stop_ev = pins.scl & s_r.last.scl & ~s_r.last.sda & pins.sda;
	assign rx_byte = {s_r.shreg[6:0], pins.sda};
	assign page = s_r.addr[7:3];

	// next data byte or protection status byte to send
	always_comb begin
		if (s_r.ptx) begin
			tx_byte = {s_r.prot[page], 7'h00};
		end else begin
			tx_byte = s_r.mem[s_r.addr];
		end
	end

	// counter step after loading one byte for transmission
	function automatic logic [7:0] next_addr(
		input logic [7:0] a,
		input logic prot_mode
	);
		logic [7:0] r;
		r = a;
		if (prot_mode) begin
			// step one page; top page wraps to the first
			r = a + 8'h08;
			if (!LARGE) begin
				r[7] = 1'b0;
			end
		end else if (LARGE) begin
			r = a + 8'h01;
		end else if (a[6:0] != 7'h7F) begin
			r = a + 8'h01; // small part holds at the top
		end
		return r;
	endfunction

	// whole protocol: one combinational step per core clock
	always_comb begin
		s_nxt = s_r;
		s_nxt.last = pins;
		if (s_r.timer != 20'h00000) begin
			s_nxt.timer = s_r.timer - 20'h00001;
		end
		if (start_ev) begin
			// start or repeated start always resyncs the byte engine
			s_nxt.st = eeprom_pkg::ST_CMD;
			// the scl fall that closes the start wraps this to zero,
			// so it is not counted as a data bit
			s_nxt.bitcnt = 4'hF;
			s_nxt.oe = 1'b0;
			s_nxt.go_tx = 1'b0;
			s_nxt.ptx = 1'b0;
		end else if (stop_ev) begin
			s_nxt.st = eeprom_pkg::ST_IDLE;
			s_nxt.oe = 1'b0;
			s_nxt.armed = 1'b0;
			s_nxt.wpend = 1'b0;
			s_nxt.wmask = 8'h00;
			s_nxt.ptx = 1'b0;
			s_nxt.go_tx = 1'b0;
			// buffered data goes in only on an unprotected page
			if (s_r.wpend && s_r.prot[page]) begin
				for (int i = 0; i < 8; i++) begin
					if (s_r.wmask[i]) begin
						s_nxt.mem[{page, 3'(i)}] = s_r.wbuf[i];
					end
				end
				s_nxt.timer = 20'(WRITE_CYC);
			end // protected page: dropped silently
			// bit programming only after eight matching bytes
			if (s_r.st == eeprom_pkg::ST_VERIFY && s_r.vok &&
				s_r.vcnt == `PAGE_BYTES) begin
				// set writes 0, clear writes 1; data untouched
				s_nxt.prot[page] = s_r.ctl[1];
				s_nxt.addr = {page, 3'h7};
				s_nxt.timer = 20'(PROT_CYC);
			end
		end else if (s_r.st == eeprom_pkg::ST_RDATA) begin
			// transmitter: master samples on high, we change on low
			if (scl_rise && s_r.bitcnt == 4'h8) begin
				s_nxt.mack = ~pins.sda;
			end
			if (scl_fall) begin
				if (s_r.bitcnt < 4'h7) begin
					s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
					s_nxt.oe = ~s_r.shreg[6];
					s_nxt.bitcnt = s_r.bitcnt + 4'h1;
				end else if (s_r.bitcnt == 4'h7) begin
					// free the line for the master's answer
					s_nxt.oe = 1'b0;
					s_nxt.bitcnt = 4'h8;
				end else if (s_r.mack) begin
					// master acked: another byte follows
					s_nxt.shreg = tx_byte;
					s_nxt.oe = ~tx_byte[7];
					s_nxt.addr = next_addr(s_r.addr, s_r.ptx);
					s_nxt.bitcnt = 4'h0;
				end else begin
					// no ack: wait quietly for stop
					s_nxt.st = eeprom_pkg::ST_IDLE;
				end
			end
		end else if (s_r.st != eeprom_pkg::ST_IDLE) begin
			// receiver: shift in on rising edges
			if (scl_rise && s_r.bitcnt < 4'h8) begin
				s_nxt.shreg = rx_byte;
				if (s_r.bitcnt == 4'h7) begin
					s_nxt.ack = 1'b1;
					unique case (s_r.st)
						eeprom_pkg::ST_CMD: begin
							// a busy part ignores even its own id
							if (rx_byte[7:4] != `CMD_ID ||
								s_r.timer != 20'h00000) begin
								s_nxt.ack = 1'b0;
								s_nxt.st = eeprom_pkg::ST_IDLE;
							end else if (rx_byte[0]) begin
								s_nxt.go_tx = 1'b1;
								s_nxt.armed = 1'b0;
							end else begin
								s_nxt.st = eeprom_pkg::ST_ADDR;
							end
						end
						eeprom_pkg::ST_ADDR: begin
							if (s_r.armed) begin
								// second write command: control byte
								unique case (rx_byte[1:0])
									`CTL_READ: begin
										s_nxt.go_tx = 1'b1;
										s_nxt.ptx = 1'b1;
									end
									`CTL_SET, `CTL_CLEAR: begin
										s_nxt.st = eeprom_pkg::ST_VERIFY;
										s_nxt.ctl = rx_byte[1:0];
										s_nxt.vcnt = 4'h0;
										s_nxt.vok = 1'b1;
									end
									default: begin
										// undefined code: refuse it
										s_nxt.ack = 1'b0;
										s_nxt.st = eeprom_pkg::ST_IDLE;
									end
								endcase
								s_nxt.armed = 1'b0;
								// page base, low bits forced to zero
								s_nxt.addr = {page, 3'h0};
							end else begin
								s_nxt.addr = LARGE ? rx_byte :
									{1'b0, rx_byte[6:0]};
								s_nxt.armed = 1'b1;
								s_nxt.st = eeprom_pkg::ST_WDATA;
							end
						end
						eeprom_pkg::ST_WDATA: begin
							// page buffer; low three bits roll in page
							s_nxt.wbuf[s_r.addr[2:0]] = rx_byte;
							s_nxt.wmask[s_r.addr[2:0]] = 1'b1;
							s_nxt.addr = {page, s_r.addr[2:0] + 3'h1};
							s_nxt.wpend = 1'b1;
							s_nxt.armed = 1'b0;
						end
						eeprom_pkg::ST_VERIFY: begin
							// compare against stored page, ascending
							if (s_r.vcnt < `PAGE_BYTES &&
								rx_byte == s_r.mem[{page, s_r.vcnt[2:0]}])
							begin
								s_nxt.ack = 1'b1;
							end else begin
								s_nxt.ack = 1'b0;
								s_nxt.vok = 1'b0;
							end
							if (s_r.vcnt <= `PAGE_BYTES) begin
								s_nxt.vcnt = s_r.vcnt + 4'h1;
							end
						end
						default: begin
							s_nxt.st = eeprom_pkg::ST_IDLE;
						end
					endcase
				end
			end
			if (scl_fall) begin
				if (s_r.bitcnt == 4'h7) begin
					// ninth clock: pull low to acknowledge
					s_nxt.oe = s_r.ack;
					s_nxt.bitcnt = 4'h8;
				end else if (s_r.bitcnt == 4'h8) begin
					s_nxt.bitcnt = 4'h0;
					s_nxt.oe = 1'b0;
					if (s_r.go_tx) begin
						// first byte leaves right after the ack
						s_nxt.st = eeprom_pkg::ST_RDATA;
						s_nxt.go_tx = 1'b0;
						s_nxt.shreg = tx_byte;
						s_nxt.oe = ~tx_byte[7];
						s_nxt.addr = next_addr(s_r.addr, s_r.ptx);
						s_nxt.mack = 1'b0;
					end
				end else begin
					s_nxt.bitcnt = s_r.bitcnt + 4'h1;
				end
			end
		end
	end

	// single state register; array resets erased, all pages open
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.last <= '1;
			s_r.prot <= `PROT_RESET;
			s_r.mem <= {256{`MEM_RESET}};
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule
`default_nettype wire

/* eeprom_regs.svh */
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH
`define CMD_ID 4'hA
`define CTL_READ 2'h0
`define CTL_SET 2'h1
`define CTL_CLEAR 2'h3
`define MEM_RESET 8'hFF
`define PROT_RESET 32'hFFFFFFFF
`define CLK_MHZ 100
`define PROT_TIME_US 4000
`define WRITE_TIME_US 8000
`define PROT_CYCLES (`PROT_TIME_US * `CLK_MHZ)
`define WRITE_CYCLES (`WRITE_TIME_US * `CLK_MHZ)
`define PAGE_BYTES 4'h8
`endif

/* eeprom_pkg.sv */
`default_nettype none
package eeprom_pkg;
	// gray sequence along idle, command, address, write, verify, read
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CMD = 3'h1,
		ST_ADDR = 3'h3,
		ST_WDATA = 3'h2,
		ST_VERIFY = 3'h6,
		ST_RDATA = 3'h7
	} state_t;
	// the two bus wires as seen after synchronising
	typedef struct packed {
		logic scl;
		logic sda;
	} bus_pins_t;
	// complete state of the device core
	typedef struct packed {
		state_t st;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic oe;
		logic ack;
		logic go_tx;
		logic ptx;
		logic mack;
		logic armed;
		logic wpend;
		logic [1:0] ctl;
		logic [3:0] vcnt;
		logic vok;
		logic [7:0] addr;
		logic [7:0] wmask;
		logic [7:0][7:0] wbuf;
		logic [31:0] prot;
		logic [255:0][7:0] mem;
		logic [19:0] timer;
		bus_pins_t last;
	} core_state_t;
endpackage
`default_nettype wire

/* sync2.sv */
`default_nettype none
module sync2 #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r; // first stage, read only by q
	// two flops; bus idles high so reset to ones
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '1;
			q <= '1;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* eeprom_core_properties.sv */
`default_nettype none
module eeprom_core_properties #(
	parameter bit LARGE = 1'b1,
	parameter int PROT_CYC = 50,
	parameter int WRITE_CYC = 50
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic busy
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// cycles spent busy, to bound programming time
	logic [19:0] busy_cnt_r;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt_r <= 20'h0;
		end else begin
			busy_cnt_r <= busy ? busy_cnt_r + 20'h1 : 20'h0;
		end
	end
	sequence s_scl_low3;
		!scl && !$past(scl, 2);
	endsequence
	property p_open_drain; sda_o == 1'b0; endproperty
	property p_drive_low; $rose(sda_oe) |-> s_scl_low3; endproperty
	property p_free_low; $fell(sda_oe) && !scl |-> s_scl_low3; endproperty
	property p_hold_high; $rose(scl) |=> $stable(sda_oe) [*8]; endproperty
	property p_busy_stop; $rose(busy) |-> scl && sda_i; endproperty
	property p_busy_len;
		$fell(busy) |-> busy_cnt_r >= PROT_CYC - 1 && busy_cnt_r <= WRITE_CYC + 1;
	endproperty
	property p_busy_mute; busy |-> !$rose(sda_oe); endproperty
	property p_stop_free; scl && $rose(sda_i) |-> ##5 !sda_oe; endproperty
	a_open_drain: assert property (p_open_drain) else $error("sda_o high");
	a_drive_low: assert property (p_drive_low) else $error("drive in high");
	a_free_low: assert property (p_free_low) else $error("release early");
	a_hold_high: assert property (p_hold_high) else $error("sda moved");
	a_busy_stop: assert property (p_busy_stop) else $error("busy no stop");
	a_busy_len: assert property (p_busy_len) else $error("busy length");
	a_busy_mute: assert property (p_busy_mute) else $error("ack in busy");
	a_stop_free: assert property (p_stop_free) else $error("held at stop");
endmodule
bind eeprom_core eeprom_core_properties #(.LARGE(LARGE), .PROT_CYC(PROT_CYC),
	.WRITE_CYC(WRITE_CYC)) props (.core_clk(core_clk), .rst_n(rst_n),
	.scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy));
`default_nettype wire

/* eeprom_master_model.sv */
`default_nettype none
module eeprom_master_model (
	input wire logic link_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_m
);
	timeunit 1ns;
	timeprecision 1ps;
	// bus idles released, the pull-up gives high
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// one link tick per step keeps data well away from scl edges
	task automatic put(input logic c, input logic d);
		@(posedge link_clk);
		scl <= c;
		sda_m <= d;
	endtask
	task automatic start();
		put(1'b1, 1'b1);
		put(1'b1, 1'b0);
		put(1'b0, 1'b0);
	endtask
	// nack before this ends a read
	task automatic stop();
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
	endtask
	task automatic bit_x(input logic d, output logic r);
		put(1'b0, d);
		put(1'b1, d);
		@(posedge link_clk);
		r = sda;
		scl <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
		end
		bit_x(1'b1, r);
		ack = !r;
	endtask
	// ack asks for the next byte, release ends the stream
	task automatic rd(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, d[i]);
		end
		bit_x(!ack, r);
	endtask
endmodule
`default_nettype wire

/* tb_eeprom_core.sv */
`default_nettype none
module tb_eeprom_core;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PROT_CYC = 40; // short programming times
	localparam int WRITE_CYC = 60;
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, sda_m, sda_o, sda_oe, busy;
	wire logic sda;
	int num_errors = 0;
	int checked = 0;
	assign sda = sda_m & ~sda_oe; // pull-up when nobody pulls
	initial forever #5 core_clk = ~core_clk;
	initial begin
		#3;
		forever #62.5 link_clk = ~link_clk;
	end
	eeprom_core #(.LARGE(1'b1), .PROT_CYC(PROT_CYC), .WRITE_CYC(WRITE_CYC)) DUT (
		.core_clk(core_clk), .rst_n(rst_n), .scl(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .busy(busy));
	eeprom_master_model m (.link_clk(link_clk), .sda(sda), .scl(scl),
		.sda_m(sda_m));
	function automatic logic [7:0] pat(input logic [7:0] a);
		return a ^ 8'hA5;
	endfunction
	task automatic wrap_up();
		$display("checks %0d, errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input string w, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s: expected %h, seen %h", w, e, s);
		end
	endtask
	task automatic send(input logic [7:0] b, input logic e);
		logic a;
		m.wr(b, a);
		check("ack", {7'h0, a}, {7'h0, e});
	endtask
	task automatic cmd(input logic [7:0] b, input logic e);
		m.start();
		send(b, e);
	endtask
	task automatic setaddr(input logic [7:0] a);
		cmd(8'hA0, 1'b1);
		send(a, 1'b1);
	endtask
	// busy shows only when programming really starts
	task automatic busy_chk(input logic e);
		repeat (8) @(posedge core_clk);
		check("busy", {7'h0, busy}, {7'h0, e});
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge core_clk);
	endtask
	task automatic wr_mem(input logic [7:0] a, input int n, input logic [7:0] x,
		input logic e);
		setaddr(a);
		for (int i = 0; i < n; i++) send(pat(a + i[7:0]) ^ x, 1'b1);
		m.stop();
		busy_chk(e);
	endtask
	// twice the write command, then eight verify bytes
	task automatic prot(input logic [7:0] c, input int bad);
		setaddr(8'hF8);
		cmd(8'hA0, 1'b1);
		send(c, 1'b1);
		for (int i = 0; i < 8; i++) begin
			send(pat(8'hF8 + i[7:0]) ^ {7'h0, i == bad}, i != bad);
		end
		m.stop();
		busy_chk(bad > 7);
	endtask
	task automatic t_read();
		logic [7:0] d;
		wr_mem(8'hF8, 8, 8'h00, 1'b1);
		wr_mem(8'h00, 1, 8'h00, 1'b1);
		setaddr(8'hFE);
		cmd(8'hA1, 1'b1);
		for (int i = 0; i < 3; i++) begin
			m.rd(i < 2, d);
			check("seq", d, pat(8'hFE + i[7:0]));
		end
		m.stop();
		cmd(8'hA1, 1'b1);
		m.rd(1'b0, d);
		m.stop();
		check("current", d, 8'hFF);
		cmd(8'hB1, 1'b0);
		m.stop();
	endtask
	task automatic t_protect();
		logic [7:0] d;
		prot(8'h01, 7);
		prot(8'hFD, 8);
		cmd(8'hA1, 1'b1);
		m.rd(1'b0, d);
		m.stop();
		check("page top", d, pat(8'hFF));
		setaddr(8'hF8);
		cmd(8'hA0, 1'b1);
		send(8'h00, 1'b1);
		m.rd(1'b1, d);
		check("bit", {7'h0, d[7]}, 8'h00);
		m.rd(1'b0, d);
		m.stop();
		check("wrap bit", {7'h0, d[7]}, 8'h01);
		wr_mem(8'hF8, 1, 8'hFF, 1'b0);
		setaddr(8'hF8);
		cmd(8'hA0, 1'b1);
		send(8'h02, 1'b0);
		m.stop();
		prot(8'h03, 8);
		setaddr(8'hF8);
		cmd(8'hA1, 1'b1);
		m.rd(1'b0, d);
		m.stop();
		check("kept", d, pat(8'hF8));
	endtask
	initial begin
		#900000;
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		t_read();
		t_protect();
		wrap_up();
	end
endmodule
`default_nettype wire
